//--- rtl/pfs_port_select.sv
// Port pin function selector: three ports, oscillator and reset pin claims
// Behaviour
// - Every port pin floats while any reset is active, clock or not.
// - Ports B and D are eight independent bidirectional bits.
// - Port C has seven bits; the top bit depends on the reset-disable fuse.
// - Each bit has its own pull-up enable.
// - External oscillator fuse gives port B bit six to the oscillator input.
// - External oscillator fuse gives port B bit seven to the amplifier output.
// - Internal RC plus async timer enable gives port B bits 7:6 to timer oscillator.
// - Reset-disable fuse programmed: port C bit six is plain I/O.
// - Reset-disable fuse clear: port C bit six is an active-low reset input.
// - Any low on the reset pin resets at once, even with clock stopped.
module pfs_port_select #(
	parameter int RST_HOLD_CYC = pfs_pkg::RST_HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Fuses
	input wire logic clk_sel_ext_osc_fuse_i,
	input wire logic reset_pin_disable_fuse_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Port B pins
	input wire logic [pfs_pkg::PORT_B_W-1:0] port_b_i,
	output logic [pfs_pkg::PORT_B_W-1:0] port_b_o,
	output logic [pfs_pkg::PORT_B_W-1:0] port_b_oe_o,
	output logic [pfs_pkg::PORT_B_W-1:0] port_b_pu_o,
	// Port C pins
	input wire logic [pfs_pkg::PORT_C_W-1:0] port_c_i,
	output logic [pfs_pkg::PORT_C_W-1:0] port_c_o,
	output logic [pfs_pkg::PORT_C_W-1:0] port_c_oe_o,
	output logic [pfs_pkg::PORT_C_W-1:0] port_c_pu_o,
	// Port D pins
	input wire logic [pfs_pkg::PORT_D_W-1:0] port_d_i,
	output logic [pfs_pkg::PORT_D_W-1:0] port_d_o,
	output logic [pfs_pkg::PORT_D_W-1:0] port_d_oe_o,
	output logic [pfs_pkg::PORT_D_W-1:0] port_d_pu_o,
	// Oscillator and reset hand-off
	output logic main_osc_en_o,
	output logic timer_osc_en_o,
	output logic sys_reset_o
);

	initial begin
		if (RST_HOLD_CYC < 1) begin
			$error("pfs_port_select: RST_HOLD_CYC must be at least one");
		end

		// Bus is one byte wide, so no port may be wider
		if (pfs_pkg::PORT_B_W > 8 || pfs_pkg::PORT_C_W > 8 || pfs_pkg::PORT_D_W > 8) begin
			$error("pfs_port_select: a port is wider than the register bus");
		end

		if (pfs_pkg::PB_SIX >= pfs_pkg::PORT_B_W || pfs_pkg::PB_SEVEN >= pfs_pkg::PORT_B_W) begin
			$error("pfs_port_select: oscillator pins lie outside port B");
		end

		if (pfs_pkg::PC_SIX >= pfs_pkg::PORT_C_W) begin
			$error("pfs_port_select: reset pin lies outside port C");
		end
		if (pfs_pkg::CFG_ASYNC_EN > 7 || pfs_pkg::STAT_FUSE_OK > 7) begin
			$error("pfs_port_select: status or config field outside the byte");
		end
	end

	localparam int BW = pfs_pkg::PORT_B_W;
	localparam int CW = pfs_pkg::PORT_C_W;
	localparam int DW = pfs_pkg::PORT_D_W;
	localparam int PW = pfs_pkg::PIN_W;

	typedef struct packed {
		logic [BW-1:0] out_b;
		logic [BW-1:0] dir_b;
		logic [BW-1:0] pull_b;
		logic [CW-1:0] out_c;
		logic [CW-1:0] dir_c;
		logic [CW-1:0] pull_c;
		logic [DW-1:0] out_d;
		logic [DW-1:0] dir_d;
		logic [DW-1:0] pull_d;
		logic async_en;
		logic fuse_ok;
		logic fuse_ext_osc;
		logic fuse_rst_dis;
		logic [PW-1:0] sync1;
		logic [PW-1:0] sync2;
		logic [BW-1:0] pad_b;
		logic [BW-1:0] oe_b;
		logic [BW-1:0] pu_b;
		logic [CW-1:0] pad_c;
		logic [CW-1:0] oe_c;
		logic [CW-1:0] pu_c;
		logic [DW-1:0] pad_d;
		logic [DW-1:0] oe_d;
		logic [DW-1:0] pu_d;
		logic main_osc;
		logic timer_osc;
		logic [7:0] rdata;
	} pfs_state_s;

	pfs_state_s st_r;
	pfs_state_s st_nxt;

	// ==========================================================
	// Reset pin catcher
	pfs_rst_if rif ();

	// Fuse is static silicon, so feeding it straight in is glitch free
	// Either reset arms the catcher, so sys_reset_o covers both
	assign rif.arm_n = (port_c_i[pfs_pkg::PC_SIX] | reset_pin_disable_fuse_i) & rst_n_i;

	pfs_reset_catch #(
		.HOLD_CYC(RST_HOLD_CYC)
	) u_catch (
		.mclk_i(mclk_i),
		.rif(rif)
	);

	// Pin reset and system reset both float the pads
	logic rst_all_n;
	assign rst_all_n = rst_n_i & ~rif.req;

	assign sys_reset_o = rif.req;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] pad8(input logic [DW-1:0] v);
		pad8 = 8'(v);
	endfunction

	function automatic logic [7:0] pad7(input logic [CW-1:0] v);
		pad7 = 8'(v);
	endfunction

	// Register selected by an address
	typedef enum {
		REG_OUT_B,
		REG_DIR_B,
		REG_PULL_B,
		REG_IN_B,
		REG_OUT_C,
		REG_DIR_C,
		REG_PULL_C,
		REG_IN_C,
		REG_OUT_D,
		REG_DIR_D,
		REG_PULL_D,
		REG_IN_D,
		REG_CFG,
		REG_STAT,
		REG_NONE
	} pfs_reg_e;

	// One decode keeps the write and read maps in step
	function automatic pfs_reg_e reg_sel(input logic [7:0] a);
		unique case (a)
			pfs_pkg::OFS_OUT_B: reg_sel = REG_OUT_B;
			pfs_pkg::OFS_DIR_B: reg_sel = REG_DIR_B;
			pfs_pkg::OFS_PULL_B: reg_sel = REG_PULL_B;
			pfs_pkg::OFS_IN_B: reg_sel = REG_IN_B;
			pfs_pkg::OFS_OUT_C: reg_sel = REG_OUT_C;
			pfs_pkg::OFS_DIR_C: reg_sel = REG_DIR_C;
			pfs_pkg::OFS_PULL_C: reg_sel = REG_PULL_C;
			pfs_pkg::OFS_IN_C: reg_sel = REG_IN_C;
			pfs_pkg::OFS_OUT_D: reg_sel = REG_OUT_D;
			pfs_pkg::OFS_DIR_D: reg_sel = REG_DIR_D;
			pfs_pkg::OFS_PULL_D: reg_sel = REG_PULL_D;
			pfs_pkg::OFS_IN_D: reg_sel = REG_IN_D;
			pfs_pkg::OFS_CFG: reg_sel = REG_CFG;
			pfs_pkg::OFS_STAT: reg_sel = REG_STAT;
			default: reg_sel = REG_NONE;
		endcase
	endfunction

	// Shared pin driver: claimed pins let go of everything
	function automatic logic [2:0] drive(input logic o, input logic d, input logic p, input logic claim);
		if (claim) begin
			drive = 3'b000;
		end else begin
			drive = {o & d, d, p & ~d};
		end
	endfunction

	// ==========================================================
	// Pin claims
	logic claim_main;
	logic claim_timer;
	logic claim_rst;
	logic [BW-1:0] claim_b;
	logic [CW-1:0] claim_c;

	always_comb begin
		claim_main = st_r.fuse_ok & st_r.fuse_ext_osc;
		claim_timer = st_r.fuse_ok & ~st_r.fuse_ext_osc & st_r.async_en;
		claim_rst = ~st_r.fuse_ok | ~st_r.fuse_rst_dis;
		claim_b = '0;
		claim_b[pfs_pkg::PB_SIX] = claim_main | claim_timer;
		claim_b[pfs_pkg::PB_SEVEN] = claim_main | claim_timer;
		claim_c = '0;
		claim_c[pfs_pkg::PC_SIX] = claim_rst;
	end

	// ==========================================================
	// Synchronised pin view, claimed bits read as zero
	logic [BW-1:0] in_b;
	logic [CW-1:0] in_c;
	logic [DW-1:0] in_d;

	always_comb begin
		in_b = st_r.sync2[BW-1:0] & ~claim_b;
		in_c = st_r.sync2[BW+CW-1:BW] & ~claim_c;
		in_d = st_r.sync2[PW-1:BW+CW];
	end

	// ==========================================================
	// Next state
	logic [2:0] drv_b [BW];
	logic [2:0] drv_c [CW];
	logic [2:0] drv_d [DW];

	genvar g;
	generate
		for (g = 0; g < BW; g++) begin : g_b
			assign drv_b[g] = drive(st_r.out_b[g], st_r.dir_b[g], st_r.pull_b[g], claim_b[g]);
		end
		for (g = 0; g < CW; g++) begin : g_c
			assign drv_c[g] = drive(st_r.out_c[g], st_r.dir_c[g], st_r.pull_c[g], claim_c[g]);
		end
		for (g = 0; g < DW; g++) begin : g_d
			assign drv_d[g] = drive(st_r.out_d[g], st_r.dir_d[g], st_r.pull_d[g], 1'b0);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;

		// Fuses caught once after reset release
		if (!st_r.fuse_ok) begin
			st_nxt.fuse_ok = 1'b1;
			st_nxt.fuse_ext_osc = clk_sel_ext_osc_fuse_i;
			st_nxt.fuse_rst_dis = reset_pin_disable_fuse_i;
		end

		// Two-stage pin synchronisers
		st_nxt.sync1 = {port_d_i, port_c_i, port_b_i};
		st_nxt.sync2 = st_r.sync1;

		// Register writes
		if (reg_wr_i) begin
			unique case (reg_sel(reg_addr_i))
				REG_OUT_B: st_nxt.out_b = reg_wdata_i[BW-1:0];
				REG_DIR_B: st_nxt.dir_b = reg_wdata_i[BW-1:0];
				REG_PULL_B: st_nxt.pull_b = reg_wdata_i[BW-1:0];
				REG_OUT_C: st_nxt.out_c = reg_wdata_i[CW-1:0];
				REG_DIR_C: st_nxt.dir_c = reg_wdata_i[CW-1:0];
				REG_PULL_C: st_nxt.pull_c = reg_wdata_i[CW-1:0];
				REG_OUT_D: st_nxt.out_d = reg_wdata_i[DW-1:0];
				REG_DIR_D: st_nxt.dir_d = reg_wdata_i[DW-1:0];
				REG_PULL_D: st_nxt.pull_d = reg_wdata_i[DW-1:0];
				REG_CFG: st_nxt.async_en = reg_wdata_i[pfs_pkg::CFG_ASYNC_EN];
				default: begin
				end
			endcase
		end

		// Register reads, data one cycle later, zero when idle or unmapped
		st_nxt.rdata = pfs_pkg::RST_BYTE;
		if (reg_rd_i) begin
			unique case (reg_sel(reg_addr_i))
				REG_OUT_B: st_nxt.rdata = pad8(st_r.out_b);
				REG_DIR_B: st_nxt.rdata = pad8(st_r.dir_b);
				REG_PULL_B: st_nxt.rdata = pad8(st_r.pull_b);
				REG_IN_B: st_nxt.rdata = pad8(in_b);
				REG_OUT_C: st_nxt.rdata = pad7(st_r.out_c);
				REG_DIR_C: st_nxt.rdata = pad7(st_r.dir_c);
				REG_PULL_C: st_nxt.rdata = pad7(st_r.pull_c);
				REG_IN_C: st_nxt.rdata = pad7(in_c);
				REG_OUT_D: st_nxt.rdata = pad8(st_r.out_d);
				REG_DIR_D: st_nxt.rdata = pad8(st_r.dir_d);
				REG_PULL_D: st_nxt.rdata = pad8(st_r.pull_d);
				REG_IN_D: st_nxt.rdata = pad8(in_d);
				REG_CFG: st_nxt.rdata[pfs_pkg::CFG_ASYNC_EN] = st_r.async_en;
				// Claims read back so software sees who owns each pin
				REG_STAT: begin
					st_nxt.rdata[pfs_pkg::STAT_EXT_OSC] = st_r.fuse_ext_osc;
					st_nxt.rdata[pfs_pkg::STAT_RST_DIS] = st_r.fuse_rst_dis;
					st_nxt.rdata[pfs_pkg::STAT_MAIN_OSC] = claim_main;
					st_nxt.rdata[pfs_pkg::STAT_TIMER_OSC] = claim_timer;
					st_nxt.rdata[pfs_pkg::STAT_PIN_RST] = claim_rst;
					st_nxt.rdata[pfs_pkg::STAT_FUSE_OK] = st_r.fuse_ok;
				end
				default: begin
				end
			endcase
		end

		// Pad drivers, one cycle behind the settings
		// Registering the pads costs a cycle but keeps every pin glitch free
		for (int i = 0; i < BW; i++) begin
			{st_nxt.pad_b[i], st_nxt.oe_b[i], st_nxt.pu_b[i]} = drv_b[i];
		end
		for (int i = 0; i < CW; i++) begin
			{st_nxt.pad_c[i], st_nxt.oe_c[i], st_nxt.pu_c[i]} = drv_c[i];
		end
		for (int i = 0; i < DW; i++) begin
			{st_nxt.pad_d[i], st_nxt.oe_d[i], st_nxt.pu_d[i]} = drv_d[i];
		end
		st_nxt.main_osc = claim_main;
		st_nxt.timer_osc = claim_timer;
	end

	// ==========================================================
	// State register; any reset drops every enable without a clock
	always_ff @(posedge mclk_i or negedge rst_all_n) begin
		if (!rst_all_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata_o = st_r.rdata;
	assign port_b_o = st_r.pad_b;
	assign port_b_oe_o = st_r.oe_b;
	assign port_b_pu_o = st_r.pu_b;
	assign port_c_o = st_r.pad_c;
	assign port_c_oe_o = st_r.oe_c;
	assign port_c_pu_o = st_r.pu_c;
	assign port_d_o = st_r.pad_d;
	assign port_d_oe_o = st_r.oe_d;
	assign port_d_pu_o = st_r.pu_d;
	assign main_osc_en_o = st_r.main_osc;
	assign timer_osc_en_o = st_r.timer_osc;

endmodule

//--- rtl/pfs_pkg.sv
// Constants shared by the port pin function selector
package pfs_pkg;

	// ==========================================================
	// Port widths
	localparam int PORT_B_W = 8;
	localparam int PORT_C_W = 7;
	localparam int PORT_D_W = 8;
	localparam int PIN_W = PORT_B_W + PORT_C_W + PORT_D_W;

	// ==========================================================
	// Pin positions
	localparam int PB_SIX = 6;
	localparam int PB_SEVEN = 7;
	localparam int PC_SIX = 6;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_OUT_B = 8'h00;
	localparam logic [7:0] OFS_DIR_B = 8'h04;
	localparam logic [7:0] OFS_PULL_B = 8'h08;
	localparam logic [7:0] OFS_IN_B = 8'h0c;
	localparam logic [7:0] OFS_OUT_C = 8'h10;
	localparam logic [7:0] OFS_DIR_C = 8'h14;
	localparam logic [7:0] OFS_PULL_C = 8'h18;
	localparam logic [7:0] OFS_IN_C = 8'h1c;
	localparam logic [7:0] OFS_OUT_D = 8'h20;
	localparam logic [7:0] OFS_DIR_D = 8'h24;
	localparam logic [7:0] OFS_PULL_D = 8'h28;
	localparam logic [7:0] OFS_IN_D = 8'h2c;
	localparam logic [7:0] OFS_CFG = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h34;

	// ==========================================================
	// Field positions
	localparam int CFG_ASYNC_EN = 0;
	localparam int STAT_EXT_OSC = 0;
	localparam int STAT_RST_DIS = 1;
	localparam int STAT_MAIN_OSC = 2;
	localparam int STAT_TIMER_OSC = 3;
	localparam int STAT_PIN_RST = 4;
	localparam int STAT_FUSE_OK = 5;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_MIN_PULSE_NS = 1500;
	localparam int RST_HOLD_CYC = (RST_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_CNT_W = 12;

endpackage

//--- rtl/pfs_rst_if.sv
// Link between the selector core and its reset pin catcher
interface pfs_rst_if;
	logic arm_n;
	logic req;

	modport core (
		output arm_n,
		input req
	);

	modport catcher (
		input arm_n,
		output req
	);
endinterface

//--- rtl/pfs_reset_catch.sv
// Reset pin catcher: asynchronous capture, clocked release and stretch
module pfs_reset_catch #(
	parameter int HOLD_CYC = pfs_pkg::RST_HOLD_CYC
) (
	// Clock
	input wire logic mclk_i,
	// Link to core
	pfs_rst_if.catcher rif
);

	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC >= (1 << pfs_pkg::RST_CNT_W)) begin
			$error("pfs_reset_catch: HOLD_CYC out of range");
		end
	end

	localparam logic [pfs_pkg::RST_CNT_W-1:0] HOLD = HOLD_CYC[pfs_pkg::RST_CNT_W-1:0];

	typedef struct packed {
		logic rel1;
		logic rel2;
		logic [pfs_pkg::RST_CNT_W-1:0] cnt;
		logic req;
	} pfs_catch_s;

	pfs_catch_s st_r;
	pfs_catch_s st_nxt;

	// ==========================================================
	// Release path
	always_comb begin
		st_nxt = st_r;
		st_nxt.rel1 = 1'b1;
		st_nxt.rel2 = st_r.rel1;
		if (!st_r.rel2) begin
			st_nxt.cnt = HOLD;
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		st_nxt.req = !st_r.rel2 || (st_r.cnt != '0);
	end

	// Low pin grabs the request with no clock edge needed
	always_ff @(posedge mclk_i or negedge rif.arm_n) begin
		if (!rif.arm_n) begin
			st_r <= '{rel1: 1'b0, rel2: 1'b0, cnt: '0, req: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rif.req = st_r.req;

endmodule

//--- verif/pfs_monitor.sv
// Assertion checker for the port pin function selector
module pfs_monitor #(
	parameter int RST_HOLD_CYC = 4
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Fuses and pads
	input wire logic clk_sel_ext_osc_fuse_i,
	input wire logic reset_pin_disable_fuse_i,
	input wire logic [pfs_pkg::PORT_C_W-1:0] port_c_i,
	// Pin controls
	input wire logic [pfs_pkg::PORT_B_W-1:0] port_b_oe_o,
	input wire logic [pfs_pkg::PORT_B_W-1:0] port_b_pu_o,
	input wire logic [pfs_pkg::PORT_C_W-1:0] port_c_oe_o,
	input wire logic [pfs_pkg::PORT_C_W-1:0] port_c_pu_o,
	input wire logic [pfs_pkg::PORT_D_W-1:0] port_d_oe_o,
	input wire logic main_osc_en_o,
	input wire logic timer_osc_en_o,
	input wire logic sys_reset_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Sync plus stretch, with slack for the release flop
	localparam int REL_MAX = RST_HOLD_CYC + 4;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// Properties
	property p_float;
		sys_reset_o |-> (|{port_b_oe_o, port_c_oe_o, port_d_oe_o}) == 1'b0;
	endproperty
	a_float: assert property (p_float) else $error("pins driven during reset");
	property p_main_claim;
		main_osc_en_o |-> (port_b_oe_o[7:6] | port_b_pu_o[7:6]) == 2'b00;
	endproperty
	a_main_claim: assert property (p_main_claim) else $error("main osc pins not released");
	property p_timer_claim;
		timer_osc_en_o |-> (port_b_oe_o[7:6] | port_b_pu_o[7:6]) == 2'b00 && !clk_sel_ext_osc_fuse_i;
	endproperty
	a_timer_claim: assert property (p_timer_claim) else $error("timer osc claim wrong");
	property p_main_fuse;
		$past(sys_reset_o, 3) == 1'b0 && !sys_reset_o |-> main_osc_en_o == clk_sel_ext_osc_fuse_i;
	endproperty
	a_main_fuse: assert property (p_main_fuse) else $error("main osc claim not from fuse");
	property p_pc6_claim;
		!reset_pin_disable_fuse_i |-> (port_c_oe_o[6] | port_c_pu_o[6]) == 1'b0;
	endproperty
	a_pc6_claim: assert property (p_pc6_claim) else $error("reset pin driven");
	property p_pin_rst;
		!reset_pin_disable_fuse_i && !port_c_i[6] |-> sys_reset_o;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("low reset pin ignored");
	property p_pc6_io;
		reset_pin_disable_fuse_i && $past(sys_reset_o) == 1'b0 |-> !sys_reset_o;
	endproperty
	a_pc6_io: assert property (p_pc6_io) else $error("plain pin caused reset");
	property p_stretch;
		!reset_pin_disable_fuse_i && $rose(port_c_i[6]) |-> sys_reset_o[*5] ##[1:REL_MAX] !sys_reset_o;
	endproperty
	a_stretch: assert property (p_stretch) else $error("pin reset release wrong");

	// ==========================================================
	// Coverage
	c_main: cover property (main_osc_en_o);
	c_timer: cover property (timer_osc_en_o);
	c_pin: cover property (!reset_pin_disable_fuse_i && $rose(port_c_i[6]));
endmodule

bind pfs_port_select pfs_monitor #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.clk_sel_ext_osc_fuse_i(clk_sel_ext_osc_fuse_i), .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i),
	.port_c_i(port_c_i), .port_b_oe_o(port_b_oe_o), .port_b_pu_o(port_b_pu_o), .port_c_oe_o(port_c_oe_o),
	.port_c_pu_o(port_c_pu_o), .port_d_oe_o(port_d_oe_o), .main_osc_en_o(main_osc_en_o),
	.timer_osc_en_o(timer_osc_en_o), .sys_reset_o(sys_reset_o));

//--- verif/pfs_board.sv
// Board model: pad levels, pull-ups, crystal and reset pin
module pfs_board (
	// Clock and crystal
	input wire logic mclk_i,
	input wire logic osc_on_i,
	// Device side
	input wire logic [22:0] oe_i,
	input wire logic [22:0] o_i,
	input wire logic [22:0] pu_i,
	// Board drivers
	input wire logic [22:0] drv_i,
	input wire logic [22:0] val_i,
	output logic [22:0] pad_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [22:0] last_r = '0;
	logic xtal_r = 1'b0;
	always @(posedge mclk_i) begin
		xtal_r <= osc_on_i ? ~xtal_r : 1'b0;
		last_r <= pad_o;
	end
	// A floating pad flips so a stale level never reads as valid
	always_comb begin
		for (int i = 0; i < 23; i++) begin
			pad_o[i] = oe_i[i] ? o_i[i] : drv_i[i] ? val_i[i] : pu_i[i] ? 1'b1 : ~last_r[i];
		end
		if (osc_on_i) begin
			pad_o[6] = xtal_r;
		end
	end
endmodule

//--- verif/tb.sv
// Self-checking bench for the port pin function selector
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HOLD_CYC = 4;
	logic mclk_i = 1'b0;
	logic run_clk = 1'b1;
	logic rst_n_i = 1'b0;
	logic ext_f = 1'b0;
	logic dis_f = 1'b1;
	logic [7:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [22:0] pad, oe, o, pu;
	logic [22:0] drv = '1;
	logic [22:0] val = '1;
	logic main_en, timer_en, sys_rst;
	int mismatches = 0;
	int check_count = 0;
	always #2.5 if (run_clk) mclk_i = ~mclk_i;

	pfs_port_select #(.RST_HOLD_CYC(HOLD_CYC)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.clk_sel_ext_osc_fuse_i(ext_f), .reset_pin_disable_fuse_i(dis_f),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .port_b_i(pad[7:0]), .port_b_o(o[7:0]), .port_b_oe_o(oe[7:0]), .port_b_pu_o(pu[7:0]),
		.port_c_i(pad[14:8]), .port_c_o(o[14:8]), .port_c_oe_o(oe[14:8]), .port_c_pu_o(pu[14:8]),
		.port_d_i(pad[22:15]), .port_d_o(o[22:15]), .port_d_oe_o(oe[22:15]), .port_d_pu_o(pu[22:15]),
		.main_osc_en_o(main_en), .timer_osc_en_o(timer_en), .sys_reset_o(sys_rst));
	pfs_board u_board (.mclk_i(mclk_i), .osc_on_i(main_en | timer_en), .oe_i(oe), .o_i(o), .pu_i(pu),
		.drv_i(drv), .val_i(val), .pad_o(pad));

	// ==========================================================
	// Shared tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [22:0] got, input logic [22:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 chk(23'(rdata), 23'(e));
	endtask
	// Counts edges until the stretched reset drops
	task automatic wait_rel(input int lim, output int n);
		n = 0;
		while (sys_rst !== 1'b0 && n < lim) begin
			@(posedge mclk_i);
			#1 n++;
		end
		if (n >= lim) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic do_reset(input logic e, input logic d);
		int n;
		rst_n_i <= 1'b0;
		ext_f <= e;
		dis_f <= d;
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		wait_rel(40, n);
		@(posedge mclk_i);
	endtask

	// ==========================================================
	// Scenarios
	task automatic run_cfg(input logic e, input logic d, input logic a);
		logic [7:0] base [3] = '{pfs_pkg::OFS_OUT_B, pfs_pkg::OFS_OUT_C, pfs_pkg::OFS_OUT_D};
		int lo [3] = '{0, 8, 15};
		logic [22:0] dir, cl, ie;
		logic mn, tm;
		mn = e;
		tm = !e && a;
		dir = {8'ha5, 7'h25, 8'ha5};
		cl = {8'h0, !d, 6'h0, {2{mn | tm}}, 6'h0};
		@(posedge mclk_i);
		val <= {8'h96, d ? 7'h1a : 7'h5a, 8'h96};
		drv <= ~dir;
		do_reset(e, d);
		wr_reg(pfs_pkg::OFS_CFG, {7'h0, a});
		for (int p = 0; p < 3; p++) begin
			wr_reg(base[p] + 8'h04, 8'ha5);
			wr_reg(base[p], 8'h3c);
			wr_reg(base[p] + 8'h08, 8'hff);
		end
		repeat (4) @(posedge mclk_i);
		#1 chk(oe, dir & ~cl);
		chk(pu, ~dir & ~cl);
		chk(o & (dir | cl), {8'h3c, 7'h3c, 8'h3c} & dir & ~cl);
		chk({21'h0, main_en, timer_en}, {21'h0, mn, tm});
		ie = (({8'h3c, 7'h3c, 8'h3c} & dir) | (val & ~dir)) & ~cl;
		for (int p = 0; p < 3; p++) begin
			rd_reg(base[p] + 8'h0c, 8'(ie >> lo[p]) & (p == 1 ? 8'h7f : 8'hff));
		end
		rd_reg(pfs_pkg::OFS_STAT, {2'b0, 1'b1, !d, tm, mn, d, e});
		rd_reg(pfs_pkg::OFS_CFG, {7'h0, a});
		rd_reg(8'h38, 8'h00);
		// Reset with the clock stopped must still float every pin
		run_clk = 1'b0;
		rst_n_i = 1'b0;
		#10 chk(oe, 23'h0);
		chk(23'(sys_rst), 23'h1);
		run_clk = 1'b1;
		$display("test cfg %0b%0b%0b done", e, d, a);
	endtask
	task automatic t_pin();
		int n;
		do_reset(1'b1, 1'b0);
		wr_reg(pfs_pkg::OFS_DIR_D, 8'hff);
		repeat (2) @(posedge mclk_i);
		#1 chk(oe, {8'hff, 15'h0});
		run_clk = 1'b0;
		#3 val[14] = 1'b0;
		#10 chk(oe, 23'h0);
		chk(23'(sys_rst), 23'h1);
		run_clk = 1'b1;
		repeat (300) @(posedge mclk_i);
		val[14] <= 1'b1;
		wait_rel(20, n);
		// Two release flops, the stretch, then one edge to see it drop
		chk(23'(n), 23'(HOLD_CYC + 3));
		@(posedge mclk_i);
		rd_reg(pfs_pkg::OFS_DIR_D, 8'h00);
		$display("test pin reset done");
	endtask

	initial begin
		run_cfg(1'b0, 1'b1, 1'b0);
		run_cfg(1'b0, 1'b1, 1'b1);
		run_cfg(1'b1, 1'b0, 1'b0);
		run_cfg(1'b1, 1'b0, 1'b1);
		t_pin();
		close_out();
	end
endmodule
